// >>> rtl/nvmcfg_autoload.sv
// configuration word autoload with axi4-lite register access
//
// Added by the designer: the AXI4-Lite register port.
`timescale 1ns/10ps
`default_nettype none
module nvmcfg_autoload #(
    parameter int ADDR_W = 10
) (
    input wire logic core_clk, // 125 mhz core clock
    input wire logic nrst, // synchronous reset, active low
    input wire logic [ADDR_W-1:0] s_axi_awaddr, // write address
    input wire logic s_axi_awvalid, // write address valid
    output logic s_axi_awready, // write address ready
    input wire logic [31:0] s_axi_wdata, // write data
    input wire logic [3:0] s_axi_wstrb, // write byte strobes
    input wire logic s_axi_wvalid, // write data valid
    output logic s_axi_wready, // write data ready
    output logic [1:0] s_axi_bresp, // write response
    output logic s_axi_bvalid, // write response valid
    input wire logic s_axi_bready, // write response ready
    input wire logic [ADDR_W-1:0] s_axi_araddr, // read address
    input wire logic s_axi_arvalid, // read address valid
    output logic s_axi_arready, // read address ready
    output logic [31:0] s_axi_rdata, // read data
    output logic [1:0] s_axi_rresp, // read response
    output logic s_axi_rvalid, // read data valid
    input wire logic s_axi_rready, // read data ready
    output var nvmcfg_pkg::nvmcfg_rd_req_t nvm_rd, // word read request
    input wire logic nvm_rd_ack, // read done pulse
    input wire logic [15:0] nvm_rd_data, // word read back
    output var nvmcfg_pkg::nvmcfg_wr_req_t nvm_wr, // word write pulse
    output logic autoload_done, // all words loaded
    output logic [14:0] readonly_region_end, // last protected word
    output logic readonly_region_present, // protection active
    output logic [22:0] boot_rom_base, // boot rom byte base
    output logic usb_host_function_enable, // usb host visible
    output logic aux_function_enable, // aux function visible
    output logic [7:0] usb_host_irq_pin, // usb interrupt pin reg
    output logic [7:0] aux_function_irq_pin, // aux interrupt pin reg
    output logic [3:0] usb_host_device_type, // usb device type
    output logic usb_host_mem_window_enable // function 5 memory bar
);
    // ---------------- autoload sequencer ----------------
    nvmcfg_pkg::nvmcfg_al_state_t al_state_ff, nxt_al_state;
    logic [1:0] al_word_ff, nxt_al_word;
    logic [14:0] al_addr;
    logic al_take;

    assign al_addr = (al_word_ff == 2'h0) ? 15'(nvmcfg_pkg::IDX_RO_END) :
                     (al_word_ff == 2'h1) ? 15'(nvmcfg_pkg::IDX_BOOT_CTL) :
                                            15'(nvmcfg_pkg::IDX_FUNC_CTL);
    assign al_take = (al_state_ff == nvmcfg_pkg::AL_WAIT) && nvm_rd_ack;

    always_comb
    begin
        nxt_al_state = al_state_ff;
        nxt_al_word = al_word_ff;
        case (al_state_ff)
            nvmcfg_pkg::AL_READ:
            begin
                nxt_al_state = nvmcfg_pkg::AL_WAIT;
            end
            nvmcfg_pkg::AL_WAIT:
            begin
                if (nvm_rd_ack)
                begin
                    if (al_word_ff == 2'h2)
                    begin
                        nxt_al_state = nvmcfg_pkg::AL_DONE;
                    end
                    else
                    begin
                        nxt_al_state = nvmcfg_pkg::AL_READ;
                        nxt_al_word = al_word_ff + 2'h1;
                    end
                end
            end
            nvmcfg_pkg::AL_DONE:
            begin
                nxt_al_state = nvmcfg_pkg::AL_DONE;
            end
            default:
            begin
                nxt_al_state = nvmcfg_pkg::AL_READ;
                nxt_al_word = 2'h0;
            end
        endcase
    end

    always_ff @(posedge core_clk)
    begin
        if (!nrst)
        begin
            al_state_ff <= nvmcfg_pkg::AL_READ;
            al_word_ff <= 2'h0;
        end
        else
        begin
            al_state_ff <= nxt_al_state;
            al_word_ff <= nxt_al_word;
        end
    end

    assign nvm_rd = '{req: (al_state_ff == nvmcfg_pkg::AL_WAIT),
                      addr: al_addr};
    assign autoload_done = (al_state_ff == nvmcfg_pkg::AL_DONE);

    // ---------------- axi4-lite write side ----------------
    logic aw_held_ff, w_held_ff, bvalid_ff;
    logic [ADDR_W-1:0] aw_addr_ff;
    logic [31:0] w_data_ff;
    logic [3:0] w_strb_ff;
    logic [1:0] bresp_ff;
    logic wr_fire;
    logic [7:0] wr_idx;
    logic wr_hit_ro_end, wr_hit_boot, wr_hit_func, wr_hit_stat, wr_hit_cmd;
    logic wr_mapped;

    // holding both halves lets the master present them in any order
    assign s_axi_awready = !aw_held_ff && !bvalid_ff;
    assign s_axi_wready = !w_held_ff && !bvalid_ff;
    assign wr_fire = aw_held_ff && w_held_ff && !bvalid_ff;
    assign wr_idx = 8'(aw_addr_ff >> 2);
    assign wr_hit_ro_end = (wr_idx == nvmcfg_pkg::IDX_RO_END);
    assign wr_hit_boot = (wr_idx == nvmcfg_pkg::IDX_BOOT_CTL);
    assign wr_hit_func = (wr_idx == nvmcfg_pkg::IDX_FUNC_CTL);
    assign wr_hit_stat = (wr_idx == nvmcfg_pkg::IDX_STATUS);
    assign wr_hit_cmd = (wr_idx == nvmcfg_pkg::IDX_NVM_WRITE);
    assign wr_mapped = (aw_addr_ff[1:0] == 2'h0) && (wr_hit_ro_end ||
        wr_hit_boot || wr_hit_func || wr_hit_stat || wr_hit_cmd ||
        wr_idx == nvmcfg_pkg::IDX_FUNC_STATE ||
        wr_idx == nvmcfg_pkg::IDX_BOOT_BASE);

    always_ff @(posedge core_clk)
    begin
        if (!nrst)
        begin
            aw_held_ff <= 1'b0;
            w_held_ff <= 1'b0;
            bvalid_ff <= 1'b0;
            bresp_ff <= nvmcfg_pkg::RESP_OKAY;
            aw_addr_ff <= '0;
            w_data_ff <= 32'h0000_0000;
            w_strb_ff <= 4'h0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held_ff <= 1'b1;
                aw_addr_ff <= s_axi_awaddr;
            end
            else if (wr_fire)
            begin
                aw_held_ff <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held_ff <= 1'b1;
                w_data_ff <= s_axi_wdata;
                w_strb_ff <= s_axi_wstrb;
            end
            else if (wr_fire)
            begin
                w_held_ff <= 1'b0;
            end
            if (wr_fire)
            begin
                bvalid_ff <= 1'b1;
                bresp_ff <= wr_mapped ? nvmcfg_pkg::RESP_OKAY :
                                        nvmcfg_pkg::RESP_SLVERR;
            end
            else if (s_axi_bready)
            begin
                bvalid_ff <= 1'b0;
            end
        end
    end

    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;

    // ---------------- configuration words ----------------
    logic [15:0] ro_end_ff, boot_ctl_ff, func_ctl_ff;
    logic [15:0] strobed;
    nvmcfg_pkg::nvmcfg_func_ctl_t fc;

    assign strobed = {w_strb_ff[1] ? w_data_ff[15:8] : 8'h00,
                      w_strb_ff[0] ? w_data_ff[7:0] : 8'h00};
    assign fc = nvmcfg_pkg::nvmcfg_func_ctl_t'(func_ctl_ff);

    // the autoload copy wins over a software write in the same cycle
    function automatic logic [15:0] word_next(
        input logic [15:0] cur,
        input logic load,
        input logic sw,
        input logic [15:0] sw_val,
        input logic [1:0] strb
    );
        logic [15:0] v;
        v = cur;
        if (sw)
        begin
            v[15:8] = strb[1] ? sw_val[15:8] : cur[15:8];
            v[7:0] = strb[0] ? sw_val[7:0] : cur[7:0];
        end
        if (load)
        begin
            v = nvm_rd_data;
        end
        return v;
    endfunction : word_next

    always_ff @(posedge core_clk)
    begin
        if (!nrst)
        begin
            ro_end_ff <= nvmcfg_pkg::RST_RO_END;
            boot_ctl_ff <= nvmcfg_pkg::RST_BOOT_CTL;
            func_ctl_ff <= nvmcfg_pkg::RST_FUNC_CTL;
        end
        else
        begin
            ro_end_ff <= word_next(ro_end_ff, al_take && al_word_ff == 2'h0,
                wr_fire && wr_hit_ro_end, strobed, w_strb_ff[1:0]);
            boot_ctl_ff <= word_next(boot_ctl_ff,
                al_take && al_word_ff == 2'h1,
                wr_fire && wr_hit_boot, strobed, w_strb_ff[1:0]);
            func_ctl_ff <= word_next(func_ctl_ff,
                al_take && al_word_ff == 2'h2,
                wr_fire && wr_hit_func, strobed, w_strb_ff[1:0]);
        end
    end

    // ---------------- applied configuration ----------------
    always_ff @(posedge core_clk)
    begin
        if (!nrst)
        begin
            readonly_region_end <= 15'h0000;
            readonly_region_present <= 1'b0;
            boot_rom_base <= 23'h000000;
            usb_host_function_enable <= 1'b0;
            aux_function_enable <= 1'b0;
            usb_host_irq_pin <= 8'h03;
            aux_function_irq_pin <= 8'h04;
            usb_host_device_type <= nvmcfg_pkg::DEVTYPE_NATIVE;
            usb_host_mem_window_enable <= 1'b1;
        end
        else
        begin
            readonly_region_end <= ro_end_ff[14:0];
            readonly_region_present <= (ro_end_ff[14:0] != 15'h0000);
            boot_rom_base <= {boot_ctl_ff[14:0], 8'h00};
            usb_host_function_enable <= fc.usb_host_function_enable;
            aux_function_enable <= fc.aux_function_enable;
            usb_host_irq_pin <= nvmcfg_pkg::IRQ_PIN_BASE +
                8'(fc.usb_host_irq_pin_select);
            aux_function_irq_pin <= nvmcfg_pkg::IRQ_PIN_BASE +
                8'(fc.aux_function_irq_pin_select);
            usb_host_device_type <= fc.usb_host_legacy_type ?
                nvmcfg_pkg::DEVTYPE_LEGACY :
                nvmcfg_pkg::DEVTYPE_NATIVE;
            usb_host_mem_window_enable <=
                fc.usb_host_mem_window_enable;
        end
    end

    // ---------------- host write path to the memory ----------------
    logic [14:0] cmd_addr;
    logic cmd_protected, cmd_issue, refused_ff;
    nvmcfg_pkg::nvmcfg_wr_req_t nvm_wr_ff;

    assign cmd_addr = w_data_ff[nvmcfg_pkg::WCMD_ADDR_LSB +: 15];
    // full 15-bit compare so the region can reach word 7fff
    assign cmd_protected = (ro_end_ff[14:0] != 15'h0000) &&
                           (cmd_addr <= ro_end_ff[14:0]);
    assign cmd_issue = wr_fire && wr_hit_cmd && (w_strb_ff == 4'hf);

    always_ff @(posedge core_clk)
    begin
        if (!nrst)
        begin
            nvm_wr_ff <= '0;
            refused_ff <= 1'b0;
        end
        else
        begin
            nvm_wr_ff.req <= cmd_issue && !cmd_protected;
            nvm_wr_ff.addr <= cmd_addr;
            nvm_wr_ff.data <= w_data_ff[15:0];
            // a new refusal wins over a clear in the same cycle
            refused_ff <= (cmd_issue && cmd_protected) ||
                (refused_ff && !(wr_fire && wr_hit_stat && w_strb_ff[0] &&
                 w_data_ff[nvmcfg_pkg::ST_REFUSED_BIT]));
        end
    end

    assign nvm_wr = nvm_wr_ff;

    // ---------------- axi4-lite read side ----------------
    logic rvalid_ff;
    logic [31:0] rdata_ff, rd_word;
    logic [1:0] rresp_ff;
    logic [7:0] rd_idx;
    logic rd_hit;
    logic [15:0] func_state;

    assign func_state = func_ctl_ff & 16'ha000;
    assign s_axi_arready = !rvalid_ff;
    assign rd_idx = 8'(s_axi_araddr >> 2);
    assign rd_hit = (s_axi_araddr[1:0] == 2'h0) &&
        (rd_idx == nvmcfg_pkg::IDX_RO_END || rd_idx ==
         nvmcfg_pkg::IDX_BOOT_CTL || rd_idx == nvmcfg_pkg::IDX_FUNC_CTL ||
         rd_idx == nvmcfg_pkg::IDX_FUNC_STATE || rd_idx ==
         nvmcfg_pkg::IDX_BOOT_BASE || rd_idx == nvmcfg_pkg::IDX_STATUS ||
         rd_idx == nvmcfg_pkg::IDX_NVM_WRITE);
    assign rd_word =
        (rd_idx == nvmcfg_pkg::IDX_RO_END) ? {16'h0000, ro_end_ff} :
        (rd_idx == nvmcfg_pkg::IDX_BOOT_CTL) ? {16'h0000, boot_ctl_ff} :
        (rd_idx == nvmcfg_pkg::IDX_FUNC_CTL) ? {16'h0000, func_ctl_ff} :
        (rd_idx == nvmcfg_pkg::IDX_FUNC_STATE) ? {16'h0000, func_state} :
        (rd_idx == nvmcfg_pkg::IDX_BOOT_BASE) ? {9'h000, boot_rom_base} :
        (rd_idx == nvmcfg_pkg::IDX_STATUS) ?
            {30'h0000_0000, refused_ff, autoload_done} :
        32'h0000_0000;

    always_ff @(posedge core_clk)
    begin
        if (!nrst)
        begin
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h0000_0000;
            rresp_ff <= nvmcfg_pkg::RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            rvalid_ff <= 1'b1;
            rdata_ff <= rd_hit ? rd_word : 32'h0000_0000;
            rresp_ff <= rd_hit ? nvmcfg_pkg::RESP_OKAY :
                                 nvmcfg_pkg::RESP_SLVERR;
        end
        else if (s_axi_rready)
        begin
            rvalid_ff <= 1'b0;
        end
    end

    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;

    // ---------------- assertions ----------------
    a_ro_end_apply: assert property (@(posedge core_clk) disable iff (!nrst)
        $past(nrst) |-> readonly_region_end == $past(ro_end_ff[14:0]))
        else $error("protected end not taken from word");
    a_ro_none: assert property (@(posedge core_clk) disable iff (!nrst)
        $past(nrst) && $past(ro_end_ff[14:0]) == 15'h0000
        |-> !readonly_region_present)
        else $error("zero end field still protects");
    a_ro_top_word: assert property (@(posedge core_clk) disable iff (!nrst)
        cmd_issue && ro_end_ff[14:0] == 15'h7fff |=> !nvm_wr.req)
        else $error("top word not protected");
    a_boot_base: assert property (@(posedge core_clk) disable iff (!nrst)
        $past(nrst) |-> boot_rom_base == 23'($past(boot_ctl_ff[14:0]))
        * 23'd256)
        else $error("boot rom base not field times 256");
    a_boot_load: assert property (@(posedge core_clk) disable iff (!nrst)
        al_take && al_word_ff == 2'h1 |=> boot_ctl_ff == $past(nvm_rd_data))
        else $error("boot control word not loaded");
    a_state_mirror: assert property (@(posedge core_clk) disable iff (!nrst)
        al_take && al_word_ff == 2'h2 |=> func_state[15] ==
        $past(nvm_rd_data[15]) && func_state[13] == $past(nvm_rd_data[13]))
        else $error("function state not mirrored");
    a_usb_visible: assert property (@(posedge core_clk) disable iff (!nrst)
        al_take && al_word_ff == 2'h2 |-> ##2
        usb_host_function_enable == $past(nvm_rd_data[15], 2))
        else $error("usb host visibility wrong");
    a_aux_visible: assert property (@(posedge core_clk) disable iff (!nrst)
        al_take && al_word_ff == 2'h2 |-> ##2
        aux_function_enable == $past(nvm_rd_data[13], 2))
        else $error("aux function visibility wrong");
    a_usb_irq_pin: assert property (@(posedge core_clk) disable iff (!nrst)
        $past(nrst) |-> usb_host_irq_pin ==
        8'($past(func_ctl_ff[12:11])) + 8'h01)
        else $error("usb interrupt pin wrong");
    a_aux_irq_pin: assert property (@(posedge core_clk) disable iff (!nrst)
        $past(nrst) |-> aux_function_irq_pin ==
        8'($past(func_ctl_ff[8:7])) + 8'h01)
        else $error("aux interrupt pin wrong");
    a_dev_type: assert property (@(posedge core_clk) disable iff (!nrst)
        $past(nrst) |-> usb_host_device_type == {3'h0, $past(func_ctl_ff[6])})
        else $error("usb device type wrong");
    a_mem_window: assert property (@(posedge core_clk) disable iff (!nrst)
        $past(nrst) |-> usb_host_mem_window_enable == $past(func_ctl_ff[5]))
        else $error("memory window enable wrong");
    a_ro_drop: assert property (@(posedge core_clk) disable iff (!nrst)
        cmd_issue |=> nvm_wr.req == !$past(cmd_protected) && refused_ff ==
        ($past(cmd_protected) || $past(refused_ff)))
        else $error("protected write not dropped");
    c_autoload_done: cover property (@(posedge core_clk) disable iff (!nrst)
        $rose(autoload_done));
    c_write_refused: cover property (@(posedge core_clk) disable iff (!nrst)
        cmd_issue && cmd_protected);
    c_write_passed: cover property (@(posedge core_clk) disable iff (!nrst)
        nvm_wr.req);
    c_usb_shown: cover property (@(posedge core_clk) disable iff (!nrst)
        usb_host_function_enable && usb_host_device_type ==
        nvmcfg_pkg::DEVTYPE_LEGACY);
endmodule : nvmcfg_autoload
`default_nettype wire

// >>> rtl/nvmcfg_pkg.sv
// package for the configuration word autoload block
package nvmcfg_pkg;
    // register indices; the byte address is four times the index
    localparam logic [7:0] IDX_RO_END = 8'h2c;
    localparam logic [7:0] IDX_BOOT_CTL = 8'h2d;
    localparam logic [7:0] IDX_FUNC_CTL = 8'h2e;
    localparam logic [7:0] IDX_FUNC_STATE = 8'h30;
    localparam logic [7:0] IDX_BOOT_BASE = 8'h31;
    localparam logic [7:0] IDX_STATUS = 8'h32;
    localparam logic [7:0] IDX_NVM_WRITE = 8'h33;
    localparam logic [9:0] BYTE_PER_IDX = 10'h004;

    // reset values of the word registers
    localparam logic [15:0] RST_RO_END = 16'h0000;
    localparam logic [15:0] RST_BOOT_CTL = 16'h0000;
    localparam logic [15:0] RST_FUNC_CTL = 16'h15bf;

    // field positions
    localparam int BOOT_SHIFT = 8;
    localparam int ST_DONE_BIT = 0;
    localparam int ST_REFUSED_BIT = 1;
    localparam int WCMD_ADDR_LSB = 16;

    // device type codes and pci interrupt pin base (01h is the first pin)
    localparam logic [3:0] DEVTYPE_NATIVE = 4'h0;
    localparam logic [3:0] DEVTYPE_LEGACY = 4'h1;
    localparam logic [7:0] IRQ_PIN_BASE = 8'h01;

    // axi responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // field layout of the functions-control word
    typedef struct packed {
        logic usb_host_function_enable;
        logic rsvd14;
        logic aux_function_enable;
        logic [1:0] usb_host_irq_pin_select;
        logic [1:0] rsvd10_9;
        logic [1:0] aux_function_irq_pin_select;
        logic usb_host_legacy_type;
        logic usb_host_mem_window_enable;
        logic [4:0] rsvd4_0;
    } nvmcfg_func_ctl_t;

    // word read request toward the configuration memory controller
    typedef struct packed {
        logic req;
        logic [14:0] addr;
    } nvmcfg_rd_req_t;

    // word write request toward the configuration memory controller
    typedef struct packed {
        logic req;
        logic [14:0] addr;
        logic [15:0] data;
    } nvmcfg_wr_req_t;

    typedef enum logic [1:0] {
        AL_READ = 2'b00,
        AL_WAIT = 2'b01,
        AL_DONE = 2'b10
    } nvmcfg_al_state_t;
endpackage : nvmcfg_pkg

// >>> dv/nvmcfg_mem_model.sv
// behavioural configuration memory on the far side of the autoloader
`timescale 1ns/10ps
`default_nettype none
module nvmcfg_mem_model (
    input wire logic core_clk, // core clock
    input wire logic slow, // stretch the read latency
    input wire nvmcfg_pkg::nvmcfg_rd_req_t nvm_rd, // word read request
    input wire nvmcfg_pkg::nvmcfg_wr_req_t nvm_wr, // word write pulse
    output logic nvm_rd_ack, // read done pulse
    output logic [15:0] nvm_rd_data // word read back
);
    logic [15:0] mem [0:32767];
    logic [3:0] wait_ff = 4'h0;
    initial
    begin
        mem[15'h002c] = 16'h0010;
        mem[15'h002d] = 16'h0123;
        mem[15'h002e] = 16'ha4df;
    end
    // data is only meaningful with the ack, so it toggles otherwise
    always @(posedge core_clk)
    begin
        nvm_rd_ack <= 1'b0;
        nvm_rd_data <= ~nvm_rd_data;
        if (nvm_wr.req)
            mem[nvm_wr.addr] <= nvm_wr.data;
        if (nvm_rd.req && !nvm_rd_ack)
        begin
            wait_ff <= wait_ff + 4'h1;
            if (wait_ff == (slow ? 4'hf : 4'h0))
            begin
                wait_ff <= 4'h0;
                nvm_rd_ack <= 1'b1;
                nvm_rd_data <= mem[nvm_rd.addr];
            end
        end
    end
endmodule : nvmcfg_mem_model
`default_nettype wire

// >>> dv/nvm_config_word_autoload_tb.sv
// self-checking bench for the configuration word autoloader
`timescale 1ns/10ps
`default_nettype none
module nvm_config_word_autoload_tb;
    logic core_clk = 1'b0, nrst = 1'b0, slow = 1'b1;
    logic [9:0] s_axi_awaddr = 10'h000, s_axi_araddr = 10'h000;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'h0, usb_host_device_type;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, nvm_rd_ack, autoload_done, readonly_region_present;
    logic [1:0] s_axi_bresp, s_axi_rresp, last_bresp;
    logic [15:0] nvm_rd_data;
    nvmcfg_pkg::nvmcfg_rd_req_t nvm_rd;
    nvmcfg_pkg::nvmcfg_wr_req_t nvm_wr;
    logic [14:0] readonly_region_end;
    logic [22:0] boot_rom_base;
    logic usb_host_function_enable, aux_function_enable;
    logic usb_host_mem_window_enable;
    logic [7:0] usb_host_irq_pin, aux_function_irq_pin;
    int failures = 0, n_compared = 0, n_wr = 0;
    nvmcfg_autoload #(.ADDR_W(10)) nvmcfg_autoload_i (
        .core_clk, .nrst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .nvm_rd, .nvm_rd_ack, .nvm_rd_data,
        .nvm_wr, .autoload_done, .readonly_region_end,
        .readonly_region_present, .boot_rom_base, .usb_host_function_enable,
        .aux_function_enable, .usb_host_irq_pin, .aux_function_irq_pin,
        .usb_host_device_type, .usb_host_mem_window_enable
    );
    nvmcfg_mem_model nvmcfg_mem_model_i (
        .core_clk, .slow, .nvm_rd, .nvm_wr, .nvm_rd_ack, .nvm_rd_data
    );
    always #4 core_clk = ~core_clk;
    always @(posedge core_clk)
        if (nvm_wr.req === 1'b1)
            n_wr <= n_wr + 1;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic tally_and_finish();
        if (failures == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : tally_and_finish
    task automatic pulse_reset();
        @(posedge core_clk);
        nrst <= 1'b0;
        repeat (3) @(posedge core_clk);
        nrst <= 1'b1;
    endtask : pulse_reset
    // ready is sampled mid-cycle where it is settled, acted on at the edge
    task automatic axw(input logic [9:0] a, input logic [31:0] d,
            input logic [3:0] s);
        logic ta, tw, bv;
        @(posedge core_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        bv = 1'b0;
        while (!bv)
        begin
            @(negedge core_clk);
            ta = s_axi_awvalid & s_axi_awready;
            tw = s_axi_wvalid & s_axi_wready;
            bv = s_axi_bvalid === 1'b1;
            last_bresp = s_axi_bresp;
            @(posedge core_clk);
            if (ta)
                s_axi_awvalid <= 1'b0;
            if (tw)
                s_axi_wvalid <= 1'b0;
        end
        s_axi_bready <= 1'b0;
    endtask : axw
    task automatic axr(input logic [9:0] a, output logic [31:0] d,
            output logic [1:0] r);
        logic ta, rv;
        @(posedge core_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        rv = 1'b0;
        while (!rv)
        begin
            @(negedge core_clk);
            ta = s_axi_arvalid & s_axi_arready;
            rv = s_axi_rvalid === 1'b1;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge core_clk);
            if (ta)
                s_axi_arvalid <= 1'b0;
        end
        s_axi_rready <= 1'b0;
    endtask : axr
    task automatic rd_chk(input logic [7:0] i, input logic [31:0] exp);
        logic [31:0] d;
        logic [1:0] r;
        axr({i, 2'b00}, d, r);
        chk(d, exp);
    endtask : rd_chk
    task automatic nvm_cmd(input logic [14:0] a, input logic [15:0] d,
            input int p);
        int n0;
        n0 = n_wr;
        axw({nvmcfg_pkg::IDX_NVM_WRITE, 2'b00}, {1'b0, a, d}, 4'hf);
        @(negedge core_clk);
        chk(n_wr - n0, p);
    endtask : nvm_cmd
    function automatic logic [31:0] outs();
        return {9'h000, usb_host_function_enable, aux_function_enable,
            usb_host_irq_pin, aux_function_irq_pin, usb_host_device_type,
            usb_host_mem_window_enable};
    endfunction : outs
    // pins count from 01h for the first interrupt line
    function automatic logic [31:0] exp_outs(input logic [15:0] w);
        return {9'h000, w[15], w[13], 8'h01 + {6'h00, w[12:11]},
            8'h01 + {6'h00, w[8:7]}, {3'h0, w[6]}, w[5]};
    endfunction : exp_outs
    task automatic t_defaults();
        logic [31:0] d;
        logic [1:0] r;
        @(negedge core_clk);
        chk(outs(), exp_outs(16'h15bf));
        rd_chk(nvmcfg_pkg::IDX_RO_END, 32'h0);
        rd_chk(nvmcfg_pkg::IDX_BOOT_CTL, 32'h0);
        rd_chk(nvmcfg_pkg::IDX_FUNC_CTL, 32'h15bf);
        axr(10'h3fc, d, r);
        chk({d[29:0], r}, {30'h0, nvmcfg_pkg::RESP_SLVERR});
        axw(10'h3fc, 32'h0, 4'hf);
        chk({30'h0, last_bresp}, {30'h0, nvmcfg_pkg::RESP_SLVERR});
    endtask : t_defaults
    task automatic t_autoload(input logic [15:0] e, b, f);
        for (int i = 0; i < 400 && autoload_done !== 1'b1; i++)
            @(negedge core_clk);
        repeat (2) @(negedge core_clk);
        chk({17'h0, readonly_region_end}, {17'h0, e[14:0]});
        chk({31'h0, readonly_region_present}, {31'h0, e != 16'h0});
        chk({9'h0, boot_rom_base}, {9'h0, b[14:0], 8'h00});
        chk(outs(), exp_outs(f));
        rd_chk(nvmcfg_pkg::IDX_BOOT_CTL, {16'h0, b});
        rd_chk(nvmcfg_pkg::IDX_FUNC_CTL, {16'h0, f});
        rd_chk(nvmcfg_pkg::IDX_FUNC_STATE, {16'h0, f & 16'ha000});
        rd_chk(nvmcfg_pkg::IDX_STATUS, 32'h1);
    endtask : t_autoload
    task automatic t_protect();
        nvm_cmd(15'h0010, 16'hbeef, 0);
        rd_chk(nvmcfg_pkg::IDX_STATUS, 32'h3);
        nvm_cmd(15'h0011, 16'h1234, 1);
        axw({nvmcfg_pkg::IDX_STATUS, 2'b00}, 32'h2, 4'hf);
        rd_chk(nvmcfg_pkg::IDX_STATUS, 32'h1);
        // words for the next power-up, all above the protected end
        nvm_cmd(15'h002c, 16'h7fff, 1);
        nvm_cmd(15'h002d, 16'h7fff, 1);
        nvm_cmd(15'h002e, 16'h3d3f, 1);
    endtask : t_protect
    task automatic t_zero_region();
        nvm_cmd(15'h7fff, 16'h5555, 0);
        nvm_cmd(15'h0000, 16'h5555, 0);
        axw({nvmcfg_pkg::IDX_RO_END, 2'b00}, 32'h0, 4'h3);
        chk({30'h0, last_bresp}, {30'h0, nvmcfg_pkg::RESP_OKAY});
        repeat (2) @(negedge core_clk);
        chk({31'h0, readonly_region_present}, 32'h0);
        nvm_cmd(15'h0000, 16'h5555, 1);
    endtask : t_zero_region
    initial
    begin
        pulse_reset();
        t_defaults();
        t_autoload(16'h0010, 16'h0123, 16'ha4df);
        t_protect();
        @(posedge core_clk);
        slow <= 1'b0;
        pulse_reset();
        t_autoload(16'h7fff, 16'h7fff, 16'h3d3f);
        t_zero_region();
        tally_and_finish();
    end
    initial
    begin
        repeat (5000) @(posedge core_clk);
        failures++;
        tally_and_finish();
    end
endmodule : nvm_config_word_autoload_tb
`default_nettype wire
